// [rtl/imsx_pkg.sv]
// constants, types and helpers for the message-signalled interrupt vector block
// assumes one clock domain and word-wide configuration and memory target ports
// What this block does
// - msi vectors numbered 0..n-1, each tied to same-index mask and pending bit
// - only advertised vectors have mask/pending bits; the rest are reserved
// - reset clears all implemented msi mask and pending bits
// - 32-bit read/write msi mask; a masked vector sends no message
// - 32-bit read-only msi pending; set bit means message waiting
// - at most one extended capability per function, may coexist with msi
// - table and pending array in memory space via bar selector plus offset
// - bar may be 32 or 64 bit, must map memory; may share one bar
// - table entry is four dwords, entries every 16 bytes
// - pending bit k sits in qword k/64 bit k%64, dword k/32 bit k%32
// - message is one dword write: entry data, upper and lower address
// - other registers never share an aligned 4-kb range with these structures
// - table and pending array may share a 4-kb range but never overlap
// - isolate the structures with aligned 8-kb ranges when bar is shared
// - table and pending array may live in plain read/write memory
// - entries and pending bits numbered 0..table size field value
// - reserved capability bits read 0; read-only fields ignore writes
// - read-only capability identifier in bits 7:0 returns 11h
// - read-only next pointer in bits 15:8, zero when last in list
// - table size field holds entries minus one, 11 bits, read-only
// - function mask masks every vector without touching per-vector masks
// - extended signalling off after reset; used only when enabled and msi off
package imsx_pkg;

  // ******************************
  // capability identity
  // ******************************
  localparam logic [7:0] CAP_CODE = 8'h11;
  localparam logic [7:0] NEXT_PTR_DEF = 8'h00;
  localparam logic [7:0] BAR_FIRST_OFF = 8'h10;

  // ******************************
  // configuration dword indices
  // ******************************
  localparam int CFG_AW = 6;
  localparam logic [5:0] CFG_MSI_MASK = 6'h14;
  localparam logic [5:0] CFG_MSI_PEND = 6'h15;
  localparam logic [5:0] CFG_MSIX_HDR = 6'h1c;
  localparam logic [5:0] CFG_MSIX_TBL = 6'h1d;
  localparam logic [5:0] CFG_MSIX_PND = 6'h1e;

  // ******************************
  // control field positions in the header dword
  // ******************************
  localparam int HDR_EN_POS = 31;
  localparam int HDR_FMASK_POS = 30;
  localparam int TSIZE_W = 11;

  // ******************************
  // memory-space placement
  // ******************************
  localparam int MEM_AW = 14;
  localparam logic [2:0] TBL_BSEL = 3'h0;
  localparam logic [31:0] TBL_OFF = 32'h0000_0000;
  localparam logic [2:0] PND_BSEL = 3'h0;
  localparam logic [31:0] PND_OFF = 32'h0000_2000;
  localparam int PND_REGION_BIT = 13;
  localparam int ENTRY_BYTES = 16;
  localparam logic [1:0] VCTL_DW = 2'h3;
  localparam logic VCTL_MASK_RST = 1'b1;
  localparam logic [31:0] MSI_MASK_RST = 32'h0000_0000;
  localparam logic [31:0] MSI_PEND_RST = 32'h0000_0000;

  typedef enum {ST_IDLE, ST_FETCH, ST_LAUNCH} imsx_state_type;
  typedef enum {SND_IDLE, SND_REQ, SND_XFER} imsx_send_type;

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction : be_merge

  // lowest set bit, lowest index wins
  function automatic logic [5:0] first_set(input logic [63:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 63; i >= 0; i--)
    begin
      if (v[i])
        r = 6'(i);
    end
    return r;
  endfunction : first_set

endpackage : imsx_pkg

// [rtl/imsx_if.sv]
// carriers between the top of the vector block and its table store and sender
// assumes both ends share clk
`timescale 1ns/1ps
interface imsx_mem_if #(parameter int AW = 4);
  logic en;
  logic we;
  logic [3:0] be;
  logic [AW-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport owner (output en, we, be, addr, wdata, input rdata);
  modport store (input en, we, be, addr, wdata, output rdata);
endinterface : imsx_mem_if

interface imsx_msg_if;
  logic valid;
  logic done;
  logic [63:0] addr;
  logic [31:0] data;
  modport top (output valid, addr, data, input done);
  modport snd (input valid, addr, data, output done);
endinterface : imsx_msg_if

// [rtl/imsx_mem.sv]
// table store: byte-writable words with registered read data
// assumes one access per cycle from the owner
`timescale 1ns/1ps
module imsx_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock
  input wire logic clk,
  // access
  imsx_mem_if.store port
);

  logic [31:0] mem [DEPTH];
  logic [31:0] rdata_ff;

  // no reset on the array: plain memory, contents undefined until written
  always_ff @(posedge clk)
  begin
    if (port.en && port.we)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (port.be[i])
          mem[port.addr][8*i +: 8] <= port.wdata[8*i +: 8];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (port.en && !port.we)
      rdata_ff <= mem[port.addr];
  end

  assign port.rdata = rdata_ff;

endmodule : imsx_mem

// [rtl/imsx_send.sv]
// bus master side: requests the bus, then drives one dword message write
// assumes the bus answers gnt and then one done pulse per write
`timescale 1ns/1ps
module imsx_send
  import imsx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // message from the vector logic
  imsx_msg_if.snd msg,
  // bus master
  output logic mst_req,
  input wire logic mst_gnt,
  output logic mst_valid,
  input wire logic mst_done,
  output logic [63:0] mst_addr,
  output logic [31:0] mst_data
);

  imsx_send_type state_ff;
  imsx_send_type nxt_state;
  logic [63:0] addr_ff;
  logic [31:0] data_ff;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      SND_IDLE: if (msg.valid) nxt_state = SND_REQ;
      SND_REQ: if (mst_gnt) nxt_state = SND_XFER;
      SND_XFER: if (mst_done) nxt_state = SND_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_ff <= SND_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_ff <= 64'h0;
      data_ff <= 32'h0;
    end
    else if (state_ff == SND_IDLE && msg.valid)
    begin
      addr_ff <= msg.addr;
      data_ff <= msg.data;
    end
  end

  assign mst_req = (state_ff == SND_REQ);
  assign mst_valid = (state_ff == SND_XFER);
  assign mst_addr = addr_ff;
  assign mst_data = data_ff;
  assign msg.done = (state_ff == SND_XFER) && mst_done;

endmodule : imsx_send

// [rtl/imsx_top.sv]
// msi per-vector mask/pending and extended capability with table and pending array
// assumes cfg and mem target ports are dword wide and already decoded to this function
`timescale 1ns/1ps
module imsx_top
  import imsx_pkg::*;
#(
  parameter int MSI_VECTORS = 32,
  parameter int TABLE_ENTRIES = 4,
  parameter logic [7:0] NEXT_PTR = NEXT_PTR_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration space target
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [CFG_AW-1:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // memory space target behind the bar
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [MEM_AW-1:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_rvalid,
  // plain msi settings held elsewhere
  input wire logic msi_en,
  input wire logic [2:0] msi_mme,
  input wire logic [63:0] msi_addr,
  input wire logic [15:0] msi_data,
  // service events
  input wire logic [MSI_VECTORS-1:0] msi_event,
  input wire logic [TABLE_ENTRIES-1:0] msix_event,
  // bus master
  output logic mst_req,
  input wire logic mst_gnt,
  output logic mst_valid,
  input wire logic mst_done,
  output logic [63:0] mst_addr,
  output logic [31:0] mst_data,
  // status
  output logic msix_active
);

  localparam int NE = TABLE_ENTRIES;
  localparam int EW = (NE > 1) ? $clog2(NE) : 1;
  localparam int AW = EW + 2;
  localparam logic [31:0] MSI_IMPL = 32'((64'h1 << MSI_VECTORS) - 64'h1);
  localparam logic [TSIZE_W-1:0] TSIZE = TSIZE_W'(NE - 1);

  // ******************************
  // state
  // ******************************
  logic [31:0] msi_mask_ff;
  logic [31:0] msi_pend_ff;
  logic msix_en_ff;
  logic fmask_ff;
  logic [NE-1:0] vmask_ff;
  logic [NE-1:0] xpend_ff;
  imsx_state_type state_ff;
  imsx_state_type nxt_state;
  logic [5:0] vec_ff;
  logic is_x_ff;
  logic [1:0] widx_ff;
  logic fetch_wait_ff;
  logic [31:0] lo_ff;
  logic [31:0] hi_ff;
  logic [63:0] maddr_ff;
  logic [31:0] mdata_ff;
  logic [31:0] cfg_rdata_ff;
  logic cfg_rvalid_ff;
  logic [31:0] mem_other_ff;
  logic rd_tbl_ff;
  logic mem_rvalid_ff;

  imsx_mem_if #(.AW(AW)) tbl();
  imsx_msg_if msg();

  // ******************************
  // configuration decode
  // ******************************
  wire cw_mask = cfg_wr && (cfg_addr == CFG_MSI_MASK);
  wire cw_hdr = cfg_wr && (cfg_addr == CFG_MSIX_HDR);
  wire [31:0] hdr_merged = be_merge({msix_en_ff, fmask_ff, 30'h0}, cfg_wdata, cfg_be);
  wire [31:0] nxt_msi_mask = be_merge(msi_mask_ff, cfg_wdata, cfg_be) & MSI_IMPL;
  // one extended capability only, header at a fixed place in the list
  wire [31:0] hdr_rd = {msix_en_ff, fmask_ff, 3'h0, TSIZE,
                        NEXT_PTR, CAP_CODE};
  wire [31:0] cfg_rd_val =
    (cfg_addr == CFG_MSI_MASK) ? msi_mask_ff :
    (cfg_addr == CFG_MSI_PEND) ? msi_pend_ff :
    (cfg_addr == CFG_MSIX_HDR) ? hdr_rd :
    (cfg_addr == CFG_MSIX_TBL) ? {TBL_OFF[31:3], TBL_BSEL} :
    (cfg_addr == CFG_MSIX_PND) ? {PND_OFF[31:3], PND_BSEL} : 32'h0;

  // ******************************
  // memory-space decode
  // ******************************
  // table at bar offset 0, pending array 8 kb above: no other registers in this bar
  wire in_pnd = mem_addr[PND_REGION_BIT];
  wire [8:0] m_entry = mem_addr[12:4];
  wire [1:0] m_dw = mem_addr[3:2];
  wire [10:0] m_pdw = mem_addr[12:2];
  wire tbl_hit = !in_pnd && (m_entry < 9'(NE));
  wire vctl_hit = tbl_hit && (m_dw == VCTL_DW);
  wire store_hit = tbl_hit && (m_dw != VCTL_DW);
  wire bus_store = (mem_wr || mem_rd) && store_hit;
  wire [EW-1:0] m_eidx = m_entry[EW-1:0];
  wire [63:0] pnd_vec = 64'(xpend_ff);
  // bit k of the array is dword k/32 bit k%32
  wire [31:0] pnd_rd = (m_pdw == 11'h0) ? pnd_vec[31:0] :
                       (m_pdw == 11'h1) ? pnd_vec[63:32] : 32'h0;
  wire [31:0] vctl_rd = {31'h0, vmask_ff[m_eidx]};
  wire [31:0] other_rd = !in_pnd ? (vctl_hit ? vctl_rd : 32'h0) : pnd_rd;

  // ******************************
  // vector selection
  // ******************************
  wire msix_mode = msix_en_ff && !msi_en;
  wire [31:0] msi_ready = msi_pend_ff & ~msi_mask_ff & MSI_IMPL;
  wire [NE-1:0] x_ready = xpend_ff & ~vmask_ff & {NE{!fmask_ff}};
  wire [5:0] msi_pick = first_set(64'(msi_ready));
  wire [5:0] x_pick = first_set(64'(x_ready));
  wire [15:0] mme_mask = 16'((17'h1 << msi_mme) - 17'h1);
  wire [15:0] msi_word = (msi_data & ~mme_mask) | (16'(msi_pick) & mme_mask);
  wire start_msi = (state_ff == ST_IDLE) && msi_en && (|msi_ready);
  wire start_x = (state_ff == ST_IDLE) && msix_mode && (|x_ready);
  wire fetch_issue = (state_ff == ST_FETCH) && !fetch_wait_ff && !bus_store;
  wire fetch_last = fetch_wait_ff && (widx_ff == 2'h2);
  wire sent = (state_ff == ST_LAUNCH) && msg.done;
  wire [31:0] msi_clr = (sent && !is_x_ff) ? (32'h1 << vec_ff[4:0]) : 32'h0;
  wire [63:0] x_clr64 = (sent && is_x_ff) ? (64'h1 << vec_ff) : 64'h0;

  // ******************************
  // table store port
  // ******************************
  assign tbl.en = bus_store || fetch_issue;
  assign tbl.we = mem_wr && store_hit;
  assign tbl.be = mem_be;
  assign tbl.addr = bus_store ? {m_eidx, m_dw} : {vec_ff[EW-1:0], widx_ff};
  assign tbl.wdata = mem_wdata;

  imsx_mem #(.DEPTH(NE * 4), .AW(AW)) u_imsx_mem (
    .clk(clk),
    .port(tbl.store)
  );

  // ******************************
  // registers reached by software
  // ******************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      msi_mask_ff <= MSI_MASK_RST;
      msix_en_ff <= 1'b0;
      fmask_ff <= 1'b0;
    end
    else
    begin
      if (cw_mask)
        msi_mask_ff <= nxt_msi_mask;
      if (cw_hdr)
      begin
        msix_en_ff <= hdr_merged[HDR_EN_POS];
        fmask_ff <= hdr_merged[HDR_FMASK_POS];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      vmask_ff <= {NE{VCTL_MASK_RST}};
    else if (mem_wr && vctl_hit && mem_be[0])
      vmask_ff[m_eidx] <= mem_wdata[0];
  end

  // set wins over the completion clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      msi_pend_ff <= MSI_PEND_RST;
      xpend_ff <= '0;
    end
    else
    begin
      msi_pend_ff <= ((msi_pend_ff & ~msi_clr) | 32'(msi_event)) & MSI_IMPL;
      xpend_ff <= (xpend_ff & ~x_clr64[NE-1:0]) | msix_event;
    end
  end

  // ******************************
  // read answers, one cycle after the strobe
  // ******************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg_rdata_ff <= 32'h0;
      cfg_rvalid_ff <= 1'b0;
      mem_other_ff <= 32'h0;
      rd_tbl_ff <= 1'b0;
      mem_rvalid_ff <= 1'b0;
    end
    else
    begin
      cfg_rvalid_ff <= cfg_rd;
      if (cfg_rd)
        cfg_rdata_ff <= cfg_rd_val;
      mem_rvalid_ff <= mem_rd;
      rd_tbl_ff <= mem_rd && store_hit;
      if (mem_rd)
        mem_other_ff <= other_rd;
    end
  end

  assign cfg_rdata = cfg_rdata_ff;
  assign cfg_rvalid = cfg_rvalid_ff;
  assign mem_rdata = rd_tbl_ff ? tbl.rdata : mem_other_ff;
  assign mem_rvalid = mem_rvalid_ff;

  // ******************************
  // message sequencer
  // ******************************
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (start_msi)
          nxt_state = ST_LAUNCH;
        else if (start_x)
          nxt_state = ST_FETCH;
      end
      ST_FETCH: if (fetch_last) nxt_state = ST_LAUNCH;
      ST_LAUNCH: if (msg.done) nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vec_ff <= 6'h0;
      is_x_ff <= 1'b0;
      widx_ff <= 2'h0;
      fetch_wait_ff <= 1'b0;
    end
    else
    begin
      if (start_msi || start_x)
      begin
        vec_ff <= start_msi ? msi_pick : x_pick;
        is_x_ff <= !start_msi;
        widx_ff <= 2'h0;
      end
      else if (fetch_wait_ff)
        widx_ff <= widx_ff + 2'h1;
      fetch_wait_ff <= fetch_issue;
    end
  end

  // entry words land in order: lower address, upper address, data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lo_ff <= 32'h0;
      hi_ff <= 32'h0;
      maddr_ff <= 64'h0;
      mdata_ff <= 32'h0;
    end
    else if (start_msi)
    begin
      maddr_ff <= msi_addr;
      mdata_ff <= {16'h0, msi_word};
    end
    else if (fetch_wait_ff)
    begin
      if (widx_ff == 2'h0)
        lo_ff <= tbl.rdata;
      if (widx_ff == 2'h1)
        hi_ff <= tbl.rdata;
      if (fetch_last)
      begin
        maddr_ff <= {hi_ff, lo_ff};
        mdata_ff <= tbl.rdata;
      end
    end
  end

  // once launched the write is committed even if a mask is raised meanwhile
  assign msg.valid = (state_ff == ST_LAUNCH);
  assign msg.addr = maddr_ff;
  assign msg.data = mdata_ff;
  assign msix_active = msix_mode;

  imsx_send u_imsx_send (
    .clk(clk),
    .rst(rst),
    .msg(msg.snd),
    .mst_req(mst_req),
    .mst_gnt(mst_gnt),
    .mst_valid(mst_valid),
    .mst_done(mst_done),
    .mst_addr(mst_addr),
    .mst_data(mst_data)
  );

endmodule : imsx_top

// [verification/imsx_top_monitor.sv]
// checker for the vector block, watching only the top module's ports
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
module imsx_top_monitor
  import imsx_pkg::*;
#(
  parameter int MSI_VECTORS = 32,
  parameter int TABLE_ENTRIES = 4,
  parameter logic [7:0] NEXT_PTR = NEXT_PTR_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration reads
  input wire logic cfg_rd,
  input wire logic [CFG_AW-1:0] cfg_addr,
  input wire logic [31:0] cfg_rdata,
  // mode
  input wire logic msi_en,
  input wire logic msix_active,
  // bus master
  input wire logic mst_req,
  input wire logic mst_gnt,
  input wire logic mst_valid,
  input wire logic mst_done,
  input wire logic [63:0] mst_addr,
  input wire logic [31:0] mst_data
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ******************************
  // capability and register reads
  // ******************************
  AST_HDR_ID: assert property (
    cfg_rd && cfg_addr == CFG_MSIX_HDR |=> cfg_rdata[7:0] == CAP_CODE)
    else $error("capability identifier wrong");
  AST_HDR_NEXT: assert property (
    cfg_rd && cfg_addr == CFG_MSIX_HDR |=> cfg_rdata[15:8] == NEXT_PTR)
    else $error("next pointer wrong");
  AST_HDR_SIZE: assert property (
    cfg_rd && cfg_addr == CFG_MSIX_HDR
    |=> cfg_rdata[26:16] == 11'(TABLE_ENTRIES - 1) && cfg_rdata[29:27] == 3'h0)
    else $error("table size or reserved bits wrong");
  AST_MASK_RESV: assert property (
    cfg_rd && cfg_addr == CFG_MSI_MASK |=> (cfg_rdata >> MSI_VECTORS) == 32'h0)
    else $error("unimplemented mask bits not zero");
  AST_PEND_RESV: assert property (
    cfg_rd && cfg_addr == CFG_MSI_PEND |=> (cfg_rdata >> MSI_VECTORS) == 32'h0)
    else $error("unimplemented pending bits not zero");

  // ******************************
  // mode and message write
  // ******************************
  AST_MODE: assert property (msix_active |-> !msi_en)
    else $error("extended mode active while msi on");
  AST_RESET_QUIET: assert property ($past(rst) |-> !mst_req && !mst_valid && !msix_active)
    else $error("not quiet after reset");
  AST_VALID_AFTER_GNT: assert property ($rose(mst_valid) |-> $past(mst_gnt))
    else $error("write driven without grant");
  AST_REQ_HOLD: assert property (
    mst_req && !mst_gnt |=> mst_req && $stable(mst_addr) && $stable(mst_data))
    else $error("request dropped before grant");
  AST_VALID_HOLD: assert property (
    mst_valid && !mst_done |=> mst_valid && $stable(mst_addr) && $stable(mst_data))
    else $error("write dropped before completion");
endmodule : imsx_top_monitor

bind imsx_top imsx_top_monitor #(
  .MSI_VECTORS(MSI_VECTORS),
  .TABLE_ENTRIES(TABLE_ENTRIES),
  .NEXT_PTR(NEXT_PTR)
) u_imsx_top_monitor (
  .clk(clk), .rst(rst), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
  .msi_en(msi_en), .msix_active(msix_active), .mst_req(mst_req), .mst_gnt(mst_gnt),
  .mst_valid(mst_valid), .mst_done(mst_done), .mst_addr(mst_addr), .mst_data(mst_data)
);

// [verification/imsx_bridge_model.sv]
// host bridge model: grants the bus after a lag, completes each write, records it
// assumes the block drops its request once granted
`timescale 1ns/1ps
module imsx_bridge_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus master side of the block
  input wire logic mst_req,
  input wire logic mst_valid,
  input wire logic [63:0] mst_addr,
  input wire logic [31:0] mst_data,
  output logic mst_gnt,
  output logic mst_done,
  // lag setting and record
  input wire logic [3:0] lag,
  output logic [63:0] got_addr,
  output logic [31:0] got_data,
  output int got_count
);
  logic [3:0] wait_ff;

  // request and write phases never overlap, so one lag counter serves both
  always_ff @(posedge clk)
  begin
    mst_gnt <= 1'b0;
    mst_done <= 1'b0;
    if (rst)
    begin
      wait_ff <= 4'h0;
      got_count <= 0;
    end
    else if ((mst_req && !mst_gnt) || (mst_valid && !mst_done))
    begin
      wait_ff <= wait_ff + 4'h1;
      if (wait_ff == lag)
      begin
        wait_ff <= 4'h0;
        mst_gnt <= mst_req;
        mst_done <= mst_valid;
        if (mst_valid)
        begin
          got_addr <= mst_addr;
          got_data <= mst_data;
          got_count <= got_count + 1;
        end
      end
    end
    else
      wait_ff <= 4'h0;
  end
endmodule : imsx_bridge_model

// [verification/imsx_top_test.sv]
// self-checking bench: register reads, masking, table entries and message writes
// assumes the bridge model and the bound checker compile alongside
`timescale 1ns/1ps
module imsx_top_test
  import imsx_pkg::*;
();
  localparam int TE = 4;
  localparam logic [13:0] A_MASK = 14'(CFG_MSI_MASK);
  localparam logic [13:0] A_PEND = 14'(CFG_MSI_PEND);
  localparam logic [13:0] A_HDR = 14'(CFG_MSIX_HDR);
  localparam logic [13:0] A_TBL = 14'(CFG_MSIX_TBL);
  localparam logic [13:0] A_PND = 14'(CFG_MSIX_PND);
  localparam logic [13:0] PND_AT = PND_OFF[13:0];
  logic clk, rst, cfg_wr, cfg_rd, cfg_rvalid, mem_wr, mem_rd, mem_rvalid, msi_en, rv;
  logic mst_req, mst_gnt, mst_valid, mst_done, msix_active;
  logic [5:0] cfg_addr;
  logic [3:0] cfg_be, mem_be, msix_event, lag;
  logic [13:0] mem_addr;
  logic [31:0] cfg_wdata, cfg_rdata, mem_wdata, mem_rdata, mst_data, got_data, q;
  logic [2:0] msi_mme;
  logic [63:0] msi_addr, mst_addr, got_addr;
  logic [15:0] msi_data;
  logic [7:0] msi_event;
  int got_count;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;

  imsx_top #(.MSI_VECTORS(8), .TABLE_ENTRIES(TE)) u_imsx_top (
    .clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_be(mem_be),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .msi_en(msi_en), .msi_mme(msi_mme), .msi_addr(msi_addr), .msi_data(msi_data),
    .msi_event(msi_event), .msix_event(msix_event), .mst_req(mst_req), .mst_gnt(mst_gnt),
    .mst_valid(mst_valid), .mst_done(mst_done), .mst_addr(mst_addr), .mst_data(mst_data),
    .msix_active(msix_active));
  imsx_bridge_model u_imsx_bridge_model (
    .clk(clk), .rst(rst), .mst_req(mst_req), .mst_valid(mst_valid), .mst_addr(mst_addr),
    .mst_data(mst_data), .mst_gnt(mst_gnt), .mst_done(mst_done), .lag(lag),
    .got_addr(got_addr), .got_data(got_data), .got_count(got_count));

  // ******************************
  // clock, timeout and closing
  // ******************************
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      close_out();
    end
  end

  // ******************************
  // access and compare tasks
  // ******************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one dword access on either port; whole dwords only
  task automatic acc(input logic mem, input logic wr, input logic [13:0] a,
                     input logic [31:0] d);
    @(negedge clk);
    {mem_wr, mem_rd, cfg_wr, cfg_rd} = {mem & wr, mem & !wr, !mem & wr, !mem & !wr};
    mem_addr = a;
    cfg_addr = a[5:0];
    mem_wdata = d;
    cfg_wdata = d;
    @(negedge clk);
    {mem_wr, mem_rd, cfg_wr, cfg_rd} = 4'h0;
    q = mem ? mem_rdata : cfg_rdata;
    rv = mem ? mem_rvalid : cfg_rvalid;
  endtask : acc

  task automatic rchk(input logic mem, input logic [13:0] a, input logic [31:0] e);
    acc(mem, 1'b0, a, 32'h0);
    check(32'(rv), 32'h1);
    check(q, e);
  endtask : rchk

  task automatic wait_msg(input int c, input logic [63:0] ea, input logic [31:0] ed);
    int n;
    n = 0;
    while (got_count < c && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    check(32'(got_count), 32'(c));
    check(got_addr[63:32], ea[63:32]);
    check(got_addr[31:0], ea[31:0]);
    check(got_data, ed);
  endtask : wait_msg

  task automatic quiet(input int c);
    repeat (20) @(negedge clk);
    check(32'(got_count), 32'(c));
  endtask : quiet

  function automatic logic [31:0] hdr(input logic en, input logic fm);
    return {en, fm, 3'h0, 11'(TE - 1), NEXT_PTR_DEF, CAP_CODE};
  endfunction : hdr

  // ******************************
  // tests
  // ******************************
  initial
  begin
    {rst, cfg_wr, cfg_rd, mem_wr, mem_rd, msi_en} = 6'h20;
    {cfg_addr, mem_addr, cfg_wdata, mem_wdata} = '0;
    {cfg_be, mem_be, msi_mme, msi_event, msix_event} = {8'hff, 3'h3, 12'h000};
    msi_addr = 64'h0000_0012_fee0_1000;
    msi_data = 16'h1230;
    lag = 4'h3;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    rchk(0, A_MASK, 32'h0);
    rchk(0, A_PEND, 32'h0);
    rchk(0, A_HDR, hdr(1'b0, 1'b0));
    rchk(0, A_TBL, TBL_OFF | 32'(TBL_BSEL));
    rchk(0, A_PND, PND_OFF | 32'(PND_BSEL));
    rchk(0, 14'h003f, 32'h0);
    $display("test reset_values done");
    acc(0, 1, A_PEND, 32'hffff_ffff);
    rchk(0, A_PEND, 32'h0);
    acc(0, 1, A_HDR, 32'hffff_ffff);
    rchk(0, A_HDR, hdr(1'b1, 1'b1));
    acc(0, 1, A_HDR, 32'h0);
    acc(0, 1, A_MASK, 32'hffff_ffff);
    rchk(0, A_MASK, 32'h0000_00ff);
    $display("test read_only done");
    msi_en = 1'b1;
    acc(0, 1, A_MASK, 32'h0000_0020);
    msi_event = 8'h20;
    @(negedge clk);
    msi_event = 8'h00;
    quiet(0);
    rchk(0, A_PEND, 32'h0000_0020);
    acc(0, 1, A_MASK, 32'h0);
    wait_msg(1, msi_addr, 32'h0000_1235);
    rchk(0, A_PEND, 32'h0);
    msi_event = 8'h80;
    @(negedge clk);
    msi_event = 8'h00;
    wait_msg(2, msi_addr, 32'h0000_1237);
    $display("test plain_msi done");
    msi_en = 1'b0;
    lag = 4'h0;
    acc(0, 1, A_HDR, 32'h8000_0000);
    check(32'(msix_active), 32'h1);
    for (int k = 0; k < TE; k++)
    begin
      acc(1, 1, 14'(16 * k), 32'h0000_1000 + 32'(4 * k));
      acc(1, 1, 14'(16 * k + 4), 32'h0000_0002);
      acc(1, 1, 14'(16 * k + 8), 32'h0000_d000 + 32'(k));
    end
    rchk(1, 14'h0038, 32'h0000_d003);
    msix_event = 4'hc;
    @(negedge clk);
    msix_event = 4'h0;
    quiet(2);
    rchk(1, PND_AT, 32'h0000_000c);
    acc(1, 1, PND_AT, 32'hffff_ffff);
    rchk(1, PND_AT, 32'h0000_000c);
    acc(1, 1, 14'h003c, 32'h0);
    wait_msg(3, 64'h0000_0002_0000_100c, 32'h0000_d003);
    rchk(1, PND_AT, 32'h0000_0004);
    acc(0, 1, A_HDR, 32'hc000_0000);
    rchk(1, 14'h003c, 32'h0);
    acc(1, 1, 14'h002c, 32'h0);
    quiet(3);
    rchk(1, 14'h002c, 32'h0);
    msi_en = 1'b1;
    @(negedge clk);
    check(32'(msix_active), 32'h0);
    msi_en = 1'b0;
    acc(0, 1, A_HDR, 32'h8000_0000);
    wait_msg(4, 64'h0000_0002_0000_1008, 32'h0000_d002);
    rchk(1, PND_AT, 32'h0);
    $display("test table_vectors done");
    acc(0, 1, A_MASK, 32'h0000_000f);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rchk(0, A_HDR, hdr(1'b0, 1'b0));
    rchk(0, A_MASK, 32'h0);
    $display("test mid_reset done");
    close_out();
  end
endmodule : imsx_top_test
